// ===== verilog/plcd_pkg.sv
package plcd_pkg;
  // Clock and power-down filter times
  localparam longint CLK_HZ = 125_000_000;
  localparam longint PD_TIME_1_S = 4;
  localparam longint PD_TIME_2_S = 129;
  localparam longint PD_TIME_3_S = 515;
  localparam longint PD_CYC_1 = PD_TIME_1_S * CLK_HZ;
  localparam longint PD_CYC_2 = PD_TIME_2_S * CLK_HZ;
  localparam longint PD_CYC_3 = PD_TIME_3_S * CLK_HZ;
  localparam int PD_CNT_W = 40;

  // Window sizes in bytes
  localparam logic [31:0] PP_BASE_BYTES = 32'h0000_0008;
  localparam logic [31:0] PP_EXT_BYTES = 32'h0000_0004;
  localparam logic [31:0] UART_IO_BYTES = 32'h0000_0008;
  localparam logic [31:0] LOC_IO_BYTES = 32'h0000_0020;
  localparam logic [31:0] LOC_MEM_BYTES = 32'h0000_1000;
  localparam logic [31:0] BAR_IO_FLAG = 32'h0000_0001;

  // Configuration space dword indices
  localparam logic [5:0] CFG_DW_CMD = 6'h01;
  localparam logic [5:0] CFG_DW_BAR0 = 6'h04;
  localparam logic [5:0] CFG_DW_BAR3 = 6'h07;
  localparam int CMD_IO_EN_BIT = 0;
  localparam int CMD_MEM_EN_BIT = 1;

  // Parallel port register offsets inside their windows
  localparam logic [2:0] PP_OFS_DATA = 3'h0;
  localparam logic [2:0] PP_OFS_STATUS = 3'h1;
  localparam logic [2:0] PP_OFS_CONTROL = 3'h2;
  localparam logic [2:0] PP_OFS_EPP_ADDR = 3'h3;
  localparam logic [2:0] PP_OFS_EPP_DATA0 = 3'h4;
  localparam logic [11:0] PP_OFS_CFG_A = 12'h400;
  localparam logic [11:0] PP_OFS_CFG_B = 12'h401;
  localparam logic [11:0] PP_OFS_EXT_CTRL = 12'h402;
  localparam logic [11:0] PP_OFS_UNUSED = 12'h403;

  // Local control register
  localparam logic [7:0] LOC_OFS_CONTROL = 8'h00;
  localparam int LCC_MODE_BIT = 0;
  localparam int LCC_TEST_BIT = 1;
  localparam int LCC_FILT_BIT = 2;
  localparam int LCC_LANE_LO = 3;
  localparam int LCC_PDT_LO = 5;
  localparam int LCC_EE_CLK_BIT = 24;
  localparam int LCC_EEPROM_SELECT_PIN_BIT = 25;
  localparam int LCC_EEPROM_SERIAL_OUT_PIN_BIT = 26;
  localparam int LCC_EEPROM_SERIAL_IN_PIN_BIT = 27;
  localparam int LCC_EE_VALID_BIT = 28;
  localparam int LCC_RELOAD_BIT = 29;
  localparam logic LCC_FILT_RST = 1'b1;
  localparam logic [1:0] LCC_LANE_RST = 2'h0;
  localparam logic [1:0] LCC_PDT_RST = 2'h0;

  typedef enum logic [1:0] {
    PDT_OFF = 2'b00,
    PDT_SHORT = 2'b01,
    PDT_MID = 2'b10,
    PDT_LONG = 2'b11
  } plcd_pdt_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic io;
    logic func;
    logic [31:0] addr;
    logic [3:0] be_n;
    logic [31:0] wdata;
  } plcd_req_t;

  typedef struct packed {
    logic stb;
    logic write;
    logic ext;
    logic upper;
    logic [3:0] be_n;
    logic [31:0] wdata;
  } plcd_pp_t;
endpackage

// ===== verilog/plcd_decode.sv
// Behaviour
// - Function 1 windows 0 and 1 decode as I/O only; memory never reaches the port.
// - First port window sizes as eight bytes, second as four bytes.
// - Port windows answer only once function 1 I/O enable is set.
// - First window holds data, status, control, enhanced address, four enhanced data bytes.
// - Second window holds shared FIFO/config A, config B, extended control; 403h unassigned.
// - Local control register reachable from both functions via I/O and memory windows.
// - Byte, word, dword local accesses honour byte enables.
// - Bit 0 reads live function-mode strap.
// - Bit 1 always reads zero; the test pin is not sampled.
// - Bit 2 enables port noise filters, resets one, only in dual mode.
// - Bits 4:3 select byte lane for 8-bit memory access, reset 00.
// - Bits 6:5 pick power-down filter time: off, 4s, 129s, 515s.
// - After filter time with function 0 still ready, raise request, and interrupt when its enable is set.
// - Bits 23:7 read zero; software writes zeros.
// - Write-only bit 24 drives EEPROM clock, reset zero; software toggles it.
// - Write-only bit 25 drives EEPROM select high when one, reset zero.
// - Write-only bit 26 drives EEPROM serial data output.
// - Bit 27 reads EEPROM serial data input level.
// - Bit 28 reads one when a valid EEPROM header was found.
// - Writing one to bit 29 starts reload; clears when EEPROM read completes.
// - Second function exists only when strap selects dual-function mode.
`timescale 1ns/10ps
module plcd_decode #(
  parameter logic [plcd_pkg::PD_CNT_W-1:0] PD_CYC_SHORT = plcd_pkg::PD_CNT_W'(plcd_pkg::PD_CYC_1),
  parameter logic [plcd_pkg::PD_CNT_W-1:0] PD_CYC_MID = plcd_pkg::PD_CNT_W'(plcd_pkg::PD_CYC_2),
  parameter logic [plcd_pkg::PD_CNT_W-1:0] PD_CYC_LONG = plcd_pkg::PD_CNT_W'(plcd_pkg::PD_CYC_3)
) (
  input wire logic SYS_CLK_IN, // PCI clock
  input wire logic RST_IN, // Synchronous reset, active high
  input wire plcd_pkg::plcd_req_t REQ_IN, // Decoded target access
  output logic REQ_HIT_OUT, // Access claimed this cycle
  output logic RESP_VALID_OUT, // Answer pulse, one cycle after request
  output logic [31:0] RESP_RDATA_OUT, // Read data
  input wire logic CFG_VALID_IN, // Configuration access strobe
  input wire logic CFG_WRITE_IN, // Configuration write
  input wire logic CFG_FUNC_IN, // Target function
  input wire logic [5:0] CFG_DW_IN, // Dword index
  input wire logic [3:0] CFG_BE_N_IN, // Byte enables, active low
  input wire logic [31:0] CFG_WDATA_IN, // Write data
  output logic CFG_HIT_OUT, // Function present
  output logic [31:0] CFG_RDATA_OUT, // Configuration read data
  output plcd_pkg::plcd_pp_t PP_OUT, // Access forwarded to the port engine
  input wire logic [31:0] PP_RDATA_IN, // Port engine read data
  input wire logic MODE_STRAP_IN, // Function-mode strap pin, 0 = dual
  input wire logic TEST_PIN_IN, // Test pin, tied low on boards
  input wire logic PD_READY_IN, // Function 0 ready to power down
  input wire logic PD_IRQ_EN_IN, // Power-down interrupt enable
  output logic PD_REQ_OUT, // Power-down request
  output logic PD_IRQ_OUT, // Power-down interrupt
  output logic FILTER_EN_OUT, // Port noise filter enable
  output logic [1:0] LANE_SEL_OUT, // Byte lane for 8-bit memory access
  output logic EEPROM_CLOCK_PIN_OUT, // EEPROM clock
  output logic EEPROM_SELECT_PIN_OUT, // EEPROM chip select, active high
  output logic EEPROM_SERIAL_OUT_PIN_OUT, // Data to EEPROM
  input wire logic EEPROM_SERIAL_IN_PIN_IN, // Data from EEPROM
  input wire logic EE_VALID_IN, // Loader found a valid header
  input wire logic LOADER_DONE_IN, // Loader finished an EEPROM read
  output logic RELOAD_REQ_OUT // One-cycle reload start
);
  import plcd_pkg::*;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be_n);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (!be_n[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Base address bits that stay fixed for a window of the given size
  function automatic logic [31:0] bar_fixed(input logic [31:0] bytes);
    return bytes - 32'h0000_0001;
  endfunction

  function automatic logic [31:0] bar_size(input logic func, input logic [1:0] idx);
    logic [31:0] sz;
    sz = LOC_IO_BYTES;
    if (idx == 2'd3) begin
      sz = LOC_MEM_BYTES;
    end else if (idx == 2'd2) begin
      sz = LOC_IO_BYTES;
    end else if (func && idx == 2'd0) begin
      sz = PP_BASE_BYTES;
    end else if (func) begin
      sz = PP_EXT_BYTES;
    end else begin
      sz = UART_IO_BYTES;
    end
    return sz;
  endfunction

  function automatic logic bar_hit(input logic [31:0] bar, input logic [31:0] addr,
                                   input logic [31:0] bytes);
    logic [31:0] m;
    m = ~bar_fixed(bytes);
    return (addr & m) == (bar & m);
  endfunction

  // Strap and EEPROM data pass two flops before use
  logic strap_s1_r, strap_s2_r;
  logic eedi_s1_r, eedi_s2_r;
  always_ff @(posedge SYS_CLK_IN) begin
    strap_s1_r <= MODE_STRAP_IN;
    strap_s2_r <= strap_s1_r;
    eedi_s1_r <= EEPROM_SERIAL_IN_PIN_IN;
    eedi_s2_r <= eedi_s1_r;
  end

  wire dual_mode = ~strap_s2_r;

  // Per-function configuration state
  logic [1:0] io_en_r, mem_en_r;
  logic [31:0] bar_r [2][4];

  // function 1 present only in dual mode
  wire cfg_present = ~CFG_FUNC_IN | dual_mode;
  wire cfg_take = CFG_VALID_IN & cfg_present;
  wire cfg_is_bar = (CFG_DW_IN >= CFG_DW_BAR0) && (CFG_DW_IN <= CFG_DW_BAR3);
  wire [1:0] cfg_bar_idx = 2'(CFG_DW_IN - CFG_DW_BAR0);
  wire [31:0] cfg_bar_old = bar_r[CFG_FUNC_IN][cfg_bar_idx];
  wire [31:0] cfg_bar_mask = bar_fixed(bar_size(CFG_FUNC_IN, cfg_bar_idx));
  wire [31:0] cfg_bar_merged = be_merge(cfg_bar_old, CFG_WDATA_IN, CFG_BE_N_IN);
  wire cfg_bar_is_io = cfg_bar_idx != 2'd3;
  // low address bits read back as zero so probing yields the size
  wire [31:0] cfg_bar_nxt = (cfg_bar_merged & ~cfg_bar_mask) | (cfg_bar_is_io ? BAR_IO_FLAG : 32'h0000_0000);
  wire [31:0] cfg_cmd_rd = {30'h0000_0000, mem_en_r[CFG_FUNC_IN], io_en_r[CFG_FUNC_IN]};
  wire [31:0] cfg_rd_sel = (CFG_DW_IN == CFG_DW_CMD) ? cfg_cmd_rd :
                           cfg_is_bar ? cfg_bar_old : 32'h0000_0000;

  assign CFG_HIT_OUT = CFG_VALID_IN & cfg_present;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      io_en_r <= 2'b00;
      mem_en_r <= 2'b00;
      CFG_RDATA_OUT <= 32'h0000_0000;
      for (int f = 0; f < 2; f++) begin
        for (int b = 0; b < 4; b++) begin
          bar_r[f][b] <= (b == 3) ? 32'h0000_0000 : BAR_IO_FLAG;
        end
      end
    end else if (cfg_take) begin
      CFG_RDATA_OUT <= cfg_rd_sel;
      if (CFG_WRITE_IN && CFG_DW_IN == CFG_DW_CMD && !CFG_BE_N_IN[0]) begin
        io_en_r[CFG_FUNC_IN] <= CFG_WDATA_IN[CMD_IO_EN_BIT];
        mem_en_r[CFG_FUNC_IN] <= CFG_WDATA_IN[CMD_MEM_EN_BIT];
      end
      if (CFG_WRITE_IN && cfg_is_bar) begin
        bar_r[CFG_FUNC_IN][cfg_bar_idx] <= cfg_bar_nxt;
      end
    end
  end

  // Target access decode
  wire f_on = ~REQ_IN.func | dual_mode;
  wire f_io = REQ_IN.valid & REQ_IN.io & f_on & io_en_r[REQ_IN.func];
  wire f_mem = REQ_IN.valid & ~REQ_IN.io & f_on & mem_en_r[REQ_IN.func];
  // port windows only ever match I/O cycles of function 1
  // gated by that function's I/O enable
  wire pp_base_hit = f_io & REQ_IN.func & bar_hit(bar_r[1][0], REQ_IN.addr, PP_BASE_BYTES);
  wire pp_ext_hit = f_io & REQ_IN.func & bar_hit(bar_r[1][1], REQ_IN.addr, PP_EXT_BYTES);
  // same register behind I/O and memory windows of both functions
  wire loc_io_hit = f_io & bar_hit(bar_r[REQ_IN.func][2], REQ_IN.addr, LOC_IO_BYTES);
  wire loc_mem_hit = f_mem & bar_hit(bar_r[REQ_IN.func][3], REQ_IN.addr, LOC_MEM_BYTES);
  wire loc_hit = loc_io_hit | loc_mem_hit;
  // Offset taken inside the hit window, so a 32-byte I/O base need not sit on a 256-byte boundary
  wire [31:0] loc_win_mask = bar_fixed(loc_io_hit ? LOC_IO_BYTES : LOC_MEM_BYTES);
  wire [7:0] loc_ofs = {REQ_IN.addr[7:2], 2'b00} & loc_win_mask[7:0];
  wire lcc_sel = loc_hit && loc_ofs == LOC_OFS_CONTROL;

  // byte lane 3 of the extended window is the unassigned 403h
  wire [11:0] ext_ofs3 = PP_OFS_CFG_A + 12'h003;
  wire [3:0] ext_be_n = REQ_IN.be_n | {ext_ofs3 == PP_OFS_UNUSED, 3'b000};

  assign REQ_HIT_OUT = pp_base_hit | pp_ext_hit | loc_hit;

  // lanes of dword 0 are data, status, control, address; dword 1 the data bytes
  // lanes of the extended dword are shared FIFO/config A, config B, extended control
  assign PP_OUT.stb = pp_base_hit | pp_ext_hit;
  assign PP_OUT.write = REQ_IN.write;
  assign PP_OUT.ext = pp_ext_hit;
  assign PP_OUT.upper = pp_base_hit & REQ_IN.addr[2];
  assign PP_OUT.be_n = pp_ext_hit ? ext_be_n : REQ_IN.be_n;
  assign PP_OUT.wdata = REQ_IN.wdata;

  // Local control register state
  logic filt_en_r;
  logic [1:0] lane_sel_r;
  plcd_pdt_t pdt_r;
  logic ee_clk_r, eeprom_select_pin_r, eeprom_serial_out_pin_r;
  logic reload_busy_r, reload_req_r;

  wire lcc_wr = lcc_sel & REQ_IN.write;
  wire lcc_wr_b0 = lcc_wr & ~REQ_IN.be_n[0];
  wire lcc_wr_b3 = lcc_wr & ~REQ_IN.be_n[3];
  wire reload_start = lcc_wr_b3 & REQ_IN.wdata[LCC_RELOAD_BIT];

  // bits 23:7, 30 and 31 read zero; write-only bits read zero
  wire [31:0] lcc_rd = {2'b00, reload_busy_r, EE_VALID_IN, eedi_s2_r, 3'b000, 17'h0_0000,
                        pdt_r, lane_sel_r, filt_en_r, 1'b0, strap_s2_r};

  // lanes without their byte enable return zero
  function automatic logic [31:0] lane_mask(input logic [3:0] be_n);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{~be_n[i]}};
    end
    return m;
  endfunction

  wire [31:0] rd_sel = PP_OUT.stb ? (PP_RDATA_IN & lane_mask(PP_OUT.be_n)) :
                       lcc_sel ? (lcc_rd & lane_mask(REQ_IN.be_n)) : 32'h0000_0000;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      RESP_VALID_OUT <= 1'b0;
      RESP_RDATA_OUT <= 32'h0000_0000;
    end else begin
      RESP_VALID_OUT <= REQ_HIT_OUT;
      RESP_RDATA_OUT <= REQ_HIT_OUT ? rd_sel : 32'h0000_0000;
    end
  end

  // each field lands only when its byte lane is enabled
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      filt_en_r <= LCC_FILT_RST;
      lane_sel_r <= LCC_LANE_RST;
      pdt_r <= plcd_pdt_t'(LCC_PDT_RST);
    end else if (lcc_wr_b0) begin
      filt_en_r <= REQ_IN.wdata[LCC_FILT_BIT];
      lane_sel_r <= REQ_IN.wdata[LCC_LANE_LO +: 2];
      pdt_r <= plcd_pdt_t'(REQ_IN.wdata[LCC_PDT_LO +: 2]);
    end
  end

  // pins follow the registered bits from the write edge
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      ee_clk_r <= 1'b0;
      eeprom_select_pin_r <= 1'b0;
      eeprom_serial_out_pin_r <= 1'b0;
    end else if (lcc_wr_b3) begin
      // clock edge made by software toggling
      ee_clk_r <= REQ_IN.wdata[LCC_EE_CLK_BIT];
      // select high while bit is one
      eeprom_select_pin_r <= REQ_IN.wdata[LCC_EEPROM_SELECT_PIN_BIT];
      eeprom_serial_out_pin_r <= REQ_IN.wdata[LCC_EEPROM_SERIAL_OUT_PIN_BIT];
    end
  end

  // a start in the same cycle as done keeps the bit set
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      reload_busy_r <= 1'b0;
      reload_req_r <= 1'b0;
    end else begin
      reload_req_r <= reload_start;
      reload_busy_r <= reload_start | (reload_busy_r & ~LOADER_DONE_IN);
    end
  end

  // Power-down filter; the count restarts whenever function 0 drops readiness
  logic [PD_CNT_W-1:0] pd_cnt_r;
  logic pd_req_r;
  wire [PD_CNT_W-1:0] pd_limit = (pdt_r == PDT_SHORT) ? PD_CYC_SHORT :
                                 (pdt_r == PDT_MID) ? PD_CYC_MID : PD_CYC_LONG;
  wire pd_arm = PD_READY_IN & (pdt_r != PDT_OFF);
  // a changed setting rearms the filter from zero
  wire pdt_wr = lcc_wr_b0 && REQ_IN.wdata[LCC_PDT_LO +: 2] != pdt_r;

  // request only after the whole filter time with readiness held
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      pd_cnt_r <= '0;
      pd_req_r <= 1'b0;
    end else if (!pd_arm || pdt_wr) begin
      pd_cnt_r <= '0;
      pd_req_r <= 1'b0;
    end else if (pd_cnt_r >= pd_limit - PD_CNT_W'(1)) begin
      pd_req_r <= 1'b1;
    end else begin
      pd_cnt_r <= pd_cnt_r + PD_CNT_W'(1);
    end
  end

  assign PD_REQ_OUT = pd_req_r;
  assign PD_IRQ_OUT = pd_req_r & PD_IRQ_EN_IN;
  // filters have no effect without the port function
  assign FILTER_EN_OUT = filt_en_r & dual_mode;
  assign LANE_SEL_OUT = lane_sel_r;
  assign EEPROM_CLOCK_PIN_OUT = ee_clk_r;
  assign EEPROM_SELECT_PIN_OUT = eeprom_select_pin_r;
  assign EEPROM_SERIAL_OUT_PIN_OUT = eeprom_serial_out_pin_r;
  assign RELOAD_REQ_OUT = reload_req_r;

  // The test pin is tied low on boards, so its level is never sampled
  wire unused_test = TEST_PIN_IN;
endmodule

// ===== verification/plcd_properties.sv
`timescale 1ns/10ps
module plcd_properties (
  input wire logic SYS_CLK_IN, // Clock
  input wire logic RST_IN, // Reset
  input wire plcd_pkg::plcd_req_t REQ_IN, // Target request
  input wire logic REQ_HIT_OUT, // Claim
  input wire logic RESP_VALID_OUT, // Answer
  input wire logic CFG_VALID_IN, // Config strobe
  input wire logic CFG_FUNC_IN, // Config function
  input wire logic CFG_HIT_OUT, // Config claim
  input wire plcd_pkg::plcd_pp_t PP_OUT, // Port access
  input wire logic MODE_STRAP_IN, // Strap
  input wire logic PD_READY_IN, // Ready to sleep
  input wire logic PD_REQ_OUT, // Sleep request
  input wire logic PD_IRQ_OUT, // Sleep interrupt
  input wire logic EEPROM_SELECT_PIN_OUT, // Chip select
  input wire logic RELOAD_REQ_OUT // Reload pulse
);
  import plcd_pkg::*;
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // Only a claimed write with the top lane enabled may touch bits 31:24
  wire lane3_wr = REQ_IN.valid && REQ_IN.write && REQ_HIT_OUT && !REQ_IN.be_n[3];
  property p_mem_no_port;
    REQ_IN.valid && !REQ_IN.io |-> !PP_OUT.stb;
  endproperty
  a_mem_no_port: assert property (p_mem_no_port) else $error("memory access reached port");
  property p_ext_lane3;
    PP_OUT.stb && PP_OUT.ext |-> PP_OUT.be_n[3];
  endproperty
  a_ext_lane3: assert property (p_ext_lane3) else $error("unassigned lane forwarded");
  property p_resp_follows;
    REQ_IN.valid && REQ_HIT_OUT |=> RESP_VALID_OUT;
  endproperty
  a_resp_follows: assert property (p_resp_follows) else $error("claimed access unanswered");
  property p_no_stray;
    !(REQ_IN.valid && REQ_HIT_OUT) |=> !RESP_VALID_OUT;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without claim");
  property p_sel_cause;
    $changed(EEPROM_SELECT_PIN_OUT) |-> $past(lane3_wr) && $past(REQ_IN.wdata[25]) == EEPROM_SELECT_PIN_OUT;
  endproperty
  a_sel_cause: assert property (p_sel_cause) else $error("select moved without write");
  property p_reload_pulse;
    RELOAD_REQ_OUT |-> $past(lane3_wr && REQ_IN.wdata[29]) ##1 !RELOAD_REQ_OUT;
  endproperty
  a_reload_pulse: assert property (p_reload_pulse) else $error("bad reload pulse");
  property p_single_no_f1;
    MODE_STRAP_IN [*4] ##0 (CFG_VALID_IN && CFG_FUNC_IN) |-> !CFG_HIT_OUT;
  endproperty
  a_single_no_f1: assert property (p_single_no_f1) else $error("second function seen in single mode");
  property p_pd_drop;
    PD_REQ_OUT && !PD_READY_IN |=> !PD_REQ_OUT && !PD_IRQ_OUT;
  endproperty
  a_pd_drop: assert property (p_pd_drop) else $error("sleep request outlived ready");
endmodule

// ===== verification/plcd_eeprom_model.sv
`timescale 1ns/10ps
module plcd_eeprom_model (
  input wire logic clk_in, // System clock
  input wire logic ee_clock_in, // Serial clock
  input wire logic ee_select_in, // Chip select
  input wire logic ee_data_in, // Data from device
  input wire logic reload_in, // Reload start
  output logic ee_data_out, // Data to device
  output logic valid_out, // Header found
  output logic done_out // Loader read finished
);
  logic last_bit_r = 1'b1;
  logic [3:0] busy_cnt_r = 4'h0;
  initial valid_out = 1'b0;
  initial done_out = 1'b0;
  // data taken on the software clock edge
  always @(posedge ee_clock_in) begin
    if (ee_select_in) begin
      last_bit_r <= ee_data_in;
    end
  end
  // Released line floats to its pull-up, so stale data cannot look valid
  assign ee_data_out = ee_select_in ? last_bit_r : 1'b1;
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (reload_in) begin
      busy_cnt_r <= 4'h6;
    end else if (busy_cnt_r != 4'h0) begin
      busy_cnt_r <= busy_cnt_r - 4'h1;
      done_out <= (busy_cnt_r == 4'h1);
      valid_out <= valid_out | (busy_cnt_r == 4'h1);
    end
  end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  import plcd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  plcd_req_t req = '0;
  logic cfg_valid = 1'b0;
  logic cfg_write = 1'b0;
  logic cfg_func = 1'b0;
  logic [5:0] cfg_dw = 6'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic [3:0] cfg_be_n = 4'h0;
  logic [31:0] pp_rdata = 32'h4433_2211;
  logic strap = 1'b0;
  logic pd_ready = 1'b0;
  logic pd_irq_en = 1'b0;
  logic eeprom_serial_in_pin, ee_valid, ld_done, hit, resp, cfg_hit, chit, pd_req, pd_irq, filt, eeprom_clock_pin, eeprom_select_pin, eeprom_serial_out_pin, reload;
  logic [31:0] rdata, cfg_rdata, rd;
  logic [1:0] lane;
  plcd_pp_t pp, pp_seen;
  int n_fail = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  // Short filter counts keep the run small
  plcd_decode #(.PD_CYC_SHORT(40'h14), .PD_CYC_MID(40'h28), .PD_CYC_LONG(40'h3C)) plcd_decode_i (
    .SYS_CLK_IN(clk), .RST_IN(rst), .REQ_IN(req), .REQ_HIT_OUT(hit), .RESP_VALID_OUT(resp),
    .RESP_RDATA_OUT(rdata), .CFG_VALID_IN(cfg_valid), .CFG_WRITE_IN(cfg_write), .CFG_FUNC_IN(cfg_func),
    .CFG_DW_IN(cfg_dw), .CFG_BE_N_IN(cfg_be_n), .CFG_WDATA_IN(cfg_wdata), .CFG_HIT_OUT(cfg_hit),
    .CFG_RDATA_OUT(cfg_rdata), .PP_OUT(pp), .PP_RDATA_IN(pp_rdata), .MODE_STRAP_IN(strap),
    .TEST_PIN_IN(1'b0), .PD_READY_IN(pd_ready), .PD_IRQ_EN_IN(pd_irq_en), .PD_REQ_OUT(pd_req),
    .PD_IRQ_OUT(pd_irq), .FILTER_EN_OUT(filt), .LANE_SEL_OUT(lane), .EEPROM_CLOCK_PIN_OUT(eeprom_clock_pin),
    .EEPROM_SELECT_PIN_OUT(eeprom_select_pin), .EEPROM_SERIAL_OUT_PIN_OUT(eeprom_serial_out_pin), .EEPROM_SERIAL_IN_PIN_IN(eeprom_serial_in_pin),
    .EE_VALID_IN(ee_valid), .LOADER_DONE_IN(ld_done), .RELOAD_REQ_OUT(reload));
  plcd_eeprom_model plcd_eeprom_model_i (.clk_in(clk), .ee_clock_in(eeprom_clock_pin), .ee_select_in(eeprom_select_pin),
    .ee_data_in(eeprom_serial_out_pin), .reload_in(reload), .ee_data_out(eeprom_serial_in_pin), .valid_out(ee_valid), .done_out(ld_done));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One request cycle, then an idle cycle so valid never toggles twice in a step
  task automatic acc(input logic io, func, wr, input logic [31:0] addr, wd, input logic [3:0] be_n,
                     input logic exp_hit);
    req = '{1'b1, wr, io, func, addr, be_n, wd};
    #1 pp_seen = pp;
    check("claim", 32'(exp_hit), 32'(hit));
    @(posedge clk) #1;
    req.valid = 1'b0;
    check("answer", 32'(exp_hit), 32'(resp));
    rd = rdata;
    @(posedge clk) #1;
  endtask
  task automatic cfg(input logic wr, func, input logic [5:0] dw, input logic [31:0] wd);
    {cfg_valid, cfg_write, cfg_func, cfg_dw, cfg_wdata} = {1'b1, wr, func, dw, wd};
    #1 chit = cfg_hit;
    @(posedge clk) #1;
    cfg_valid = 1'b0;
    rd = cfg_rdata;
    @(posedge clk) #1;
  endtask
  task automatic wlcc(input logic [31:0] wd, input logic [3:0] be_n);
    acc(1'b0, 1'b1, 1'b1, 32'h8000_0000, wd, be_n, 1'b1);
  endtask
  task automatic rlcc(input logic [31:0] exp);
    acc(1'b1, 1'b0, 1'b0, 32'h0000_1020, 32'h0, 4'h0, 1'b1);
    check("local", exp, rd);
  endtask

  task automatic t_config();
    cfg(1'b1, 1'b1, CFG_DW_BAR0, 32'hFFFF_FFFF);
    cfg(1'b0, 1'b1, CFG_DW_BAR0, 32'h0);
    check("bar0 size", 32'hFFFF_FFF9, rd);
    cfg(1'b1, 1'b1, 6'h05, 32'hFFFF_FFFF);
    cfg(1'b0, 1'b1, 6'h05, 32'h0);
    check("bar1 size", 32'hFFFF_FFFD, rd);
    cfg_be_n = 4'h7;
    cfg(1'b1, 1'b1, CFG_DW_BAR0, 32'h0);
    cfg_be_n = 4'h0;
    cfg(1'b0, 1'b1, CFG_DW_BAR0, 32'h0);
    check("bar0 merge", 32'h00FF_FFF9, rd);
    cfg(1'b1, 1'b1, CFG_DW_BAR0, 32'h0000_0378);
    cfg(1'b1, 1'b1, 6'h05, 32'h0000_0778);
    cfg(1'b1, 1'b0, 6'h06, 32'h0000_1020);
    cfg(1'b1, 1'b1, CFG_DW_BAR3, 32'h8000_0000);
    cfg(1'b0, 1'b1, CFG_DW_BAR0, 32'h0);
    check("bar0 value", 32'h0000_0379, rd);
    acc(1'b1, 1'b1, 1'b0, 32'h0000_0378, 32'h0, 4'h0, 1'b0);
    cfg(1'b1, 1'b1, CFG_DW_CMD, 32'h3);
    cfg(1'b1, 1'b0, CFG_DW_CMD, 32'h3);
  endtask
  task automatic t_port();
    acc(1'b1, 1'b1, 1'b0, 32'h0000_037C, 32'h0, 4'h0, 1'b1);
    check("upper", 32'h1, 32'(pp_seen.upper));
    check("port read", 32'h4433_2211, rd);
    acc(1'b1, 1'b1, 1'b1, 32'h0000_0378, 32'h0000_00A5, 4'hE, 1'b1);
    check("base lanes", 32'h0000_000E, {27'h0, pp_seen.upper, pp_seen.be_n});
    check("port write", 32'h0000_01A5, {23'h0, pp_seen.write, pp_seen.wdata[7:0]});
    acc(1'b1, 1'b1, 1'b0, 32'h0000_0778, 32'h0, 4'h0, 1'b1);
    check("ext read", 32'h0033_2211, rd);
    check("ext lanes", 32'h0000_0018, {27'h0, pp_seen.ext, pp_seen.be_n});
    acc(1'b0, 1'b1, 1'b0, 32'h0000_0378, 32'h0, 4'h0, 1'b0);
    acc(1'b1, 1'b1, 1'b0, 32'h0000_0390, 32'h0, 4'h0, 1'b0);
  endtask
  task automatic t_local();
    wlcc(32'h2200_0038, 4'h0);
    check("pins", 32'h2, {29'h0, eeprom_clock_pin, eeprom_select_pin, eeprom_serial_out_pin});
    check("lane filter", 32'h6, {29'h0, lane, filt});
    rlcc(32'h2800_0038);
    wlcc(32'h0300_0000, 4'h7);
    check("pins", 32'h6, {29'h0, eeprom_clock_pin, eeprom_select_pin, eeprom_serial_out_pin});
    // Loader model needs six cycles to finish
    repeat (8) @(posedge clk) #1;
    rlcc(32'h1000_0038);
    wlcc(32'h0400_0000, 4'h7);
    check("pins", 32'h1, {29'h0, eeprom_clock_pin, eeprom_select_pin, eeprom_serial_out_pin});
    repeat (3) @(posedge clk) #1;
    rlcc(32'h1800_0038);
    wlcc(32'hFFFF_FF04, 4'h8);
    rlcc(32'h1800_0004);
    acc(1'b0, 1'b1, 1'b0, 32'h8000_0000, 32'h0, 4'h0, 1'b1);
    check("mem path", 32'h1800_0004, rd);
    check("filter", 32'h1, 32'(filt));
  endtask
  task automatic t_pd(input logic [1:0] code, input int lim, input logic en);
    int n;
    n = 0;
    wlcc({25'h0, code, 5'h04}, 4'hE);
    pd_irq_en = en;
    pd_ready = 1'b1;
    while (n < 80 && pd_req !== 1'b1) begin
      @(posedge clk) #1;
      n++;
    end
    if (lim != 0 && n == 80) begin
      n_fail++;
      end_sim();
    end
    check("filter time", (lim == 0) ? 32'h50 : 32'(lim), 32'(n));
    check("irq", 32'(en && lim != 0), 32'(pd_irq));
    pd_ready = 1'b0;
    repeat (2) @(posedge clk) #1;
    check("request drop", 32'h0, 32'(pd_req));
  endtask
  task automatic t_single();
    strap = 1'b1;
    repeat (4) @(posedge clk) #1;
    cfg(1'b0, 1'b1, CFG_DW_CMD, 32'h0);
    check("second function", 32'h0, 32'(chit));
    acc(1'b1, 1'b1, 1'b0, 32'h0000_0378, 32'h0, 4'h0, 1'b0);
    rlcc(32'h1800_0065);
    check("filter", 32'h0, 32'(filt));
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    t_config();
    t_port();
    t_local();
    t_pd(2'h0, 32'h0, 1'b1);
    t_pd(2'h1, 32'h14, 1'b1);
    t_pd(2'h2, 32'h28, 1'b0);
    t_pd(2'h3, 32'h3C, 1'b1);
    t_single();
    end_sim();
  end
endmodule

bind plcd_decode plcd_properties plcd_properties_i (.SYS_CLK_IN, .RST_IN, .REQ_IN, .REQ_HIT_OUT, .RESP_VALID_OUT,
  .CFG_VALID_IN, .CFG_FUNC_IN, .CFG_HIT_OUT, .PP_OUT, .MODE_STRAP_IN, .PD_READY_IN, .PD_REQ_OUT, .PD_IRQ_OUT,
  .EEPROM_SELECT_PIN_OUT, .RELOAD_REQ_OUT);
